// File: pkg/pll_ser_pkg.sv
// constants shared by both ends of the pll configuration link
// ==========================================================
// Summary of operation
// - controller starts: data falls, clock high
// - controller stops: data rises, clock high
// - data changes only while clock low
// - acknowledge low before rise, until fall
// - first byte: 7-bit address, direction bit
// - device acknowledges its own address
// - direction 0 writes, 1 reads
// - receiver acknowledges every byte; controller leaves the last read byte unacknowledged
// - controller ends each transfer with stop
// - two dummy bytes precede data, not latched
// - three latch bytes, third reserved, extras ignored
// - device address is 1100101, direction last
// - byte zero: bypass, select, 6-bit reference
// - select resets low; enables programmed values
// - feedback (p+3)*2, reference q+2
// - output ratio is feedback over reference
// - bypass gives reference one; resets low
// - select low: multiplier from choice pin
// - choice pin low x16, high x8, pulled up
// - gate pin 0 disables, 1 enables output
package pll_ser_pkg;
  // ==========================================================
  // link addressing and framing
  localparam logic [6:0] SLAVE_ADDR = 7'h65;
  localparam logic DIR_WRITE = 1'b0;
  localparam logic DIR_READ = 1'b1;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [2:0] IDX_CFG0 = 3'h2;
  localparam logic [2:0] IDX_CFG1 = 3'h3;
  localparam logic [2:0] IDX_RSVD = 3'h4;
  localparam logic [2:0] IDX_SAT = 3'h5;
  localparam logic [2:0] RD_CFG0 = 3'h0;
  localparam logic [2:0] RD_CFG1 = 3'h1;
  localparam logic [2:0] RD_RSVD = 3'h2;
  localparam logic [7:0] DUMMY_BYTE = 8'h00;
  localparam logic [7:0] IDLE_BYTE = 8'hff;
  // ==========================================================
  // configuration bytes
  localparam logic [7:0] CFG0_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] RSVD_RST = 8'h00;
  localparam int BYP_BIT = 7;
  localparam int SEL_BIT = 6;
  localparam int Q_MSB = 5;
  localparam logic [9:0] FB_OFFSET = 10'h003;
  localparam int FB_SHIFT = 1;
  localparam logic [6:0] REF_OFFSET = 7'h02;
  localparam logic [6:0] REF_BYPASSED = 7'h01;
  localparam logic [6:0] UNITY_DEN = 7'h01;
  localparam logic [9:0] MULT_PIN_LOW = 10'h010;
  localparam logic [9:0] MULT_PIN_HIGH = 10'h008;
  // ==========================================================
  // device input synchronisers
  localparam int SY_SCL = 0;
  localparam int SY_SDA = 1;
  localparam int SY_MULT = 2;
  localparam int SY_GATE = 3;
  localparam int SY_PLL = 4;
  localparam int SY_N = 5;
  localparam logic [4:0] SYNC_RST = 5'h07;
  // ==========================================================
  // controller timing and registers
  localparam int CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 160;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam logic [2:0] QTR_LAST = 3'(QTR_CYC - 1);
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_WDATA = 4'h4;
  localparam logic [3:0] REG_RDATA = 4'h8;
  localparam logic [3:0] REG_STATUS = 4'hc;
  localparam int GO_BIT = 0;
  localparam int READ_BIT = 1;
  localparam int CNT_LSB = 2;
  localparam int BUSY_BIT = 0;
  localparam int NACK_BIT = 1;
  typedef enum logic [2:0] {d_idle, d_rx, d_rx_ack, d_tx, d_tx_ack} dev_state_e;
  typedef enum logic [1:0] {m_idle, m_start, m_bit, m_stop} ctrl_state_e;
endpackage : pll_ser_pkg

// File: pkg/two_wire_if.sv
// wired two-wire bus joining the controller and the configuration slave
`timescale 1ns/1ps
`default_nettype none

interface two_wire_if;
  logic serial_clock_line; // driven by the controller only
  logic m_sda_o; // controller data out
  logic m_sda_oe_n; // controller drive enable, low drives
  logic d_sda_o; // device data out
  logic d_sda_oe_n; // device drive enable, low drives
  logic serial_data_line; // resolved line level
  // pull-up: the line is low only when an enabled driver pulls it low
  assign serial_data_line = (m_sda_oe_n | m_sda_o) & (d_sda_oe_n | d_sda_o);
  modport ctrl (output serial_clock_line, m_sda_o, m_sda_oe_n, input serial_data_line);
  modport device (input serial_clock_line, serial_data_line, output d_sda_o, d_sda_oe_n);
endinterface : two_wire_if

`default_nettype wire

// File: logic/pll_cfg_slave.sv
// two-wire configuration slave of the clock synthesizer
`timescale 1ns/1ps
`default_nettype none

module pll_cfg_slave (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset
  two_wire_if.device link, // serial clock and data lines
  input wire logic mult_choice_pin, // multiplier choice pin
  input wire logic out_gate_pin, // output gate pin
  input wire logic pll_clk_in, // clock from synthesizer core
  output logic [7:0] config_byte_zero, // divider control byte
  output logic [7:0] config_byte_one, // feedback count byte
  output logic [7:0] reserved_byte, // third latch byte
  output logic ref_divider_bypass, // reference divider bypass
  output logic serial_divider_select, // programmed values in use
  output logic [9:0] mult_num, // ratio numerator
  output logic [6:0] mult_den, // ratio denominator
  output logic clk_out, // gated clock output
  output logic differential_out_inverted // gated complement output
);

  // ==========================================================
  // functions
  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == pll_ser_pkg::IDX_SAT) ? v : v + 3'h1;
  endfunction : sat_inc

  function automatic logic [9:0] eff_feedback(input logic [7:0] p);
    eff_feedback = ({2'h0, p} + pll_ser_pkg::FB_OFFSET) << pll_ser_pkg::FB_SHIFT;
  endfunction : eff_feedback

  function automatic logic [6:0] eff_reference(input logic [7:0] c);
    if (c[pll_ser_pkg::BYP_BIT]) begin
      eff_reference = pll_ser_pkg::REF_BYPASSED;
    end else begin
      eff_reference = {1'b0, c[pll_ser_pkg::Q_MSB:0]} + pll_ser_pkg::REF_OFFSET;
    end
  endfunction : eff_reference

  // ==========================================================
  // input synchronisers
  logic [pll_ser_pkg::SY_N-1:0] sync1_ff;
  logic [pll_ser_pkg::SY_N-1:0] sync2_ff;
  logic [pll_ser_pkg::SY_N-1:0] prev_ff;
  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  // choice pin resets high to match its pull-up
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= pll_ser_pkg::SYNC_RST;
      sync2_ff <= pll_ser_pkg::SYNC_RST;
      prev_ff <= pll_ser_pkg::SYNC_RST;
    end else begin
      sync1_ff <= {pll_clk_in, out_gate_pin, mult_choice_pin,
                   link.serial_data_line, link.serial_clock_line};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  assign scl_s = sync2_ff[pll_ser_pkg::SY_SCL];
  assign sda_s = sync2_ff[pll_ser_pkg::SY_SDA];
  assign scl_rise = scl_s & ~prev_ff[pll_ser_pkg::SY_SCL];
  assign scl_fall = ~scl_s & prev_ff[pll_ser_pkg::SY_SCL];
  // data edges count only while the clock stays high
  assign start_det = scl_s & prev_ff[pll_ser_pkg::SY_SCL]
                     & prev_ff[pll_ser_pkg::SY_SDA] & ~sda_s;
  assign stop_det = scl_s & prev_ff[pll_ser_pkg::SY_SCL]
                    & ~prev_ff[pll_ser_pkg::SY_SDA] & sda_s;

  // ==========================================================
  // byte engine
  pll_ser_pkg::dev_state_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff;
  logic [2:0] byte_idx_ff;
  logic is_addr_ff;
  logic is_read_ff;
  logic mack_ff;
  logic drive_low_ff;
  logic byte_done;
  logic [7:0] tx_byte;
  logic [7:0] cfg0_ff;
  logic [7:0] cfg1_ff;
  logic [7:0] rsvd_ff;

  assign byte_done = (state_ff == pll_ser_pkg::d_rx) && scl_fall
                     && (bit_cnt_ff == pll_ser_pkg::BYTE_BITS);

  // read data in latch order; past the last latch the line stays released
  always_comb begin
    case (byte_idx_ff)
      pll_ser_pkg::RD_CFG0: tx_byte = cfg0_ff;
      pll_ser_pkg::RD_CFG1: tx_byte = cfg1_ff;
      pll_ser_pkg::RD_RSVD: tx_byte = rsvd_ff;
      default: tx_byte = pll_ser_pkg::IDLE_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= pll_ser_pkg::d_idle;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      byte_idx_ff <= 3'h0;
      is_addr_ff <= 1'b0;
      is_read_ff <= 1'b0;
      mack_ff <= 1'b0;
      drive_low_ff <= 1'b0;
    end else if (start_det) begin
      // a start restarts framing from any state
      state_ff <= pll_ser_pkg::d_rx;
      bit_cnt_ff <= 4'h0;
      byte_idx_ff <= 3'h0;
      is_addr_ff <= 1'b1;
      drive_low_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff <= pll_ser_pkg::d_idle;
      drive_low_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        pll_ser_pkg::d_idle: begin
          drive_low_ff <= 1'b0;
        end
        pll_ser_pkg::d_rx: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_s};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (byte_done) begin
            if (is_addr_ff && shift_ff[7:1] != pll_ser_pkg::SLAVE_ADDR) begin
              state_ff <= pll_ser_pkg::d_idle;
            end else begin
              // ack driven just after the fall, ahead of the next rise
              drive_low_ff <= 1'b1;
              state_ff <= pll_ser_pkg::d_rx_ack;
            end
            if (is_addr_ff) begin
              is_read_ff <= (shift_ff[0] == pll_ser_pkg::DIR_READ);
            end else begin
              byte_idx_ff <= sat_inc(byte_idx_ff);
            end
          end
        end
        pll_ser_pkg::d_rx_ack: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            is_addr_ff <= 1'b0;
            if (is_read_ff) begin
              state_ff <= pll_ser_pkg::d_tx;
              shift_ff <= tx_byte;
              drive_low_ff <= ~tx_byte[7];
              byte_idx_ff <= sat_inc(byte_idx_ff);
            end else begin
              state_ff <= pll_ser_pkg::d_rx;
              drive_low_ff <= 1'b0;
            end
          end
        end
        pll_ser_pkg::d_tx: begin
          if (scl_fall) begin
            if (bit_cnt_ff == pll_ser_pkg::LAST_BIT) begin
              drive_low_ff <= 1'b0;
              state_ff <= pll_ser_pkg::d_tx_ack;
            end else begin
              // next bit only while the clock is low
              shift_ff <= {shift_ff[6:0], 1'b0};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
              drive_low_ff <= ~shift_ff[6];
            end
          end
        end
        pll_ser_pkg::d_tx_ack: begin
          if (scl_rise) begin
            mack_ff <= ~sda_s;
          end else if (scl_fall) begin
            if (mack_ff) begin
              state_ff <= pll_ser_pkg::d_tx;
              bit_cnt_ff <= 4'h0;
              shift_ff <= tx_byte;
              drive_low_ff <= ~tx_byte[7];
              byte_idx_ff <= sat_inc(byte_idx_ff);
            end else begin
              // no ack ends the read; wait for stop or start
              state_ff <= pll_ser_pkg::d_idle;
            end
          end
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  assign link.d_sda_o = 1'b0;
  assign link.d_sda_oe_n = ~drive_low_ff;

  // ==========================================================
  // latch bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg0_ff <= pll_ser_pkg::CFG0_RST;
      cfg1_ff <= pll_ser_pkg::CFG1_RST;
      rsvd_ff <= pll_ser_pkg::RSVD_RST;
    end else if (byte_done && !is_addr_ff) begin
      // dummies and anything past the third latch fall through
      case (byte_idx_ff)
        pll_ser_pkg::IDX_CFG0: cfg0_ff <= shift_ff;
        pll_ser_pkg::IDX_CFG1: cfg1_ff <= shift_ff;
        pll_ser_pkg::IDX_RSVD: rsvd_ff <= shift_ff;
        default: cfg0_ff <= cfg0_ff;
      endcase
    end
  end

  assign config_byte_zero = cfg0_ff;
  assign config_byte_one = cfg1_ff;
  assign reserved_byte = rsvd_ff;
  assign ref_divider_bypass = cfg0_ff[pll_ser_pkg::BYP_BIT];
  assign serial_divider_select = cfg0_ff[pll_ser_pkg::SEL_BIT];

  // ==========================================================
  // multiplier ratio
  logic [9:0] num_ff;
  logic [6:0] den_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      num_ff <= pll_ser_pkg::MULT_PIN_HIGH;
      den_ff <= pll_ser_pkg::UNITY_DEN;
    end else if (cfg0_ff[pll_ser_pkg::SEL_BIT]) begin
      num_ff <= eff_feedback(cfg1_ff);
      den_ff <= eff_reference(cfg0_ff);
    end else begin
      num_ff <= sync2_ff[pll_ser_pkg::SY_MULT] ? pll_ser_pkg::MULT_PIN_HIGH
                                                : pll_ser_pkg::MULT_PIN_LOW;
      den_ff <= pll_ser_pkg::UNITY_DEN;
    end
  end

  assign mult_num = num_ff;
  assign mult_den = den_ff;

  // ==========================================================
  // output gate
  logic clk_out_ff;
  logic clk_inv_ff;

  // both legs held low while gated off
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clk_out_ff <= 1'b0;
      clk_inv_ff <= 1'b0;
    end else begin
      clk_out_ff <= sync2_ff[pll_ser_pkg::SY_GATE] & sync2_ff[pll_ser_pkg::SY_PLL];
      clk_inv_ff <= sync2_ff[pll_ser_pkg::SY_GATE] & ~sync2_ff[pll_ser_pkg::SY_PLL];
    end
  end

  assign clk_out = clk_out_ff;
  assign differential_out_inverted = clk_inv_ff;

endmodule : pll_cfg_slave

`default_nettype wire

// File: logic/two_wire_ctrl.sv
// two-wire controller programming the synthesizer, commanded over wishbone
`timescale 1ns/1ps
`default_nettype none

module two_wire_ctrl (
  input wire logic clk, // system clock
  input wire logic nrst, // asynchronous reset
  two_wire_if.ctrl link, // serial clock and data lines
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [3:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o // acknowledge
);

  // ==========================================================
  // register slave
  logic ack_ff;
  logic [31:0] dat_ff;
  logic rd_mode_ff;
  logic [1:0] cnt_ff;
  logic [23:0] wdata_ff;
  logic [23:0] rdata_ff;
  logic nack_ff;
  logic busy;
  logic go;
  logic wr_take;
  pll_ser_pkg::ctrl_state_e state_ff;

  assign busy = (state_ff != pll_ser_pkg::m_idle);
  // writes land on the edge where the master sees ack
  assign wr_take = wb_cyc_i & wb_stb_i & wb_we_i & ack_ff;
  assign go = wr_take && wb_adr_i == pll_ser_pkg::REG_CTRL && wb_sel_i[0]
              && wb_dat_i[pll_ser_pkg::GO_BIT] && !busy;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      ack_ff <= wb_cyc_i & wb_stb_i & ~ack_ff;
      case (wb_adr_i)
        pll_ser_pkg::REG_CTRL: dat_ff <= {28'h0, cnt_ff, rd_mode_ff, 1'b0};
        pll_ser_pkg::REG_WDATA: dat_ff <= {8'h0, wdata_ff};
        pll_ser_pkg::REG_RDATA: dat_ff <= {8'h0, rdata_ff};
        pll_ser_pkg::REG_STATUS: dat_ff <= {30'h0, nack_ff, busy};
        default: dat_ff <= 32'h0;
      endcase
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_mode_ff <= 1'b0;
      cnt_ff <= 2'h0;
      wdata_ff <= 24'h0;
    end else if (wr_take) begin
      if (wb_adr_i == pll_ser_pkg::REG_CTRL && wb_sel_i[0] && !busy) begin
        rd_mode_ff <= wb_dat_i[pll_ser_pkg::READ_BIT];
        cnt_ff <= wb_dat_i[pll_ser_pkg::CNT_LSB +: 2];
      end
      if (wb_adr_i == pll_ser_pkg::REG_WDATA) begin
        for (int i = 0; i < 3; i++) begin
          if (wb_sel_i[i]) begin
            wdata_ff[8*i +: 8] <= wb_dat_i[8*i +: 8];
          end
        end
      end
    end
  end

  // ==========================================================
  // bit engine: four quarters per bit, clock made by division
  logic [1:0] sda_sync_ff;
  logic sda_s;
  logic [2:0] qcnt_ff;
  logic [1:0] phase_ff;
  logic tick;
  logic scl_ff;
  logic sda_rel_ff;
  logic [2:0] bidx_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic [7:0] next_byte;
  logic [2:0] last_idx;
  logic rd_data;
  logic last_byte;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sda_sync_ff <= 2'h3;
    end else begin
      sda_sync_ff <= {sda_sync_ff[0], link.serial_data_line};
    end
  end

  assign sda_s = sda_sync_ff[1];
  assign tick = (qcnt_ff == 3'h0);
  assign last_idx = rd_mode_ff ? {1'b0, cnt_ff} : {1'b0, cnt_ff} + pll_ser_pkg::IDX_CFG0;
  assign rd_data = rd_mode_ff && bidx_ff != 3'h0;
  assign last_byte = (bidx_ff == last_idx);

  // byte following the current one in a write frame
  always_comb begin
    if (bidx_ff < pll_ser_pkg::RD_RSVD) begin
      next_byte = pll_ser_pkg::DUMMY_BYTE;
    end else begin
      next_byte = wdata_ff[8*(bidx_ff - pll_ser_pkg::RD_RSVD) +: 8];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= pll_ser_pkg::m_idle;
      qcnt_ff <= 3'h0;
      phase_ff <= 2'h0;
      scl_ff <= 1'b1;
      sda_rel_ff <= 1'b1;
      bidx_ff <= 3'h0;
      bit_ff <= 4'h0;
      sh_ff <= 8'h00;
      nack_ff <= 1'b0;
      rdata_ff <= 24'h0;
    end else if (state_ff == pll_ser_pkg::m_idle) begin
      qcnt_ff <= pll_ser_pkg::QTR_LAST;
      phase_ff <= 2'h0;
      if (go) begin
        state_ff <= pll_ser_pkg::m_start;
        nack_ff <= 1'b0;
      end
    end else begin
      qcnt_ff <= tick ? pll_ser_pkg::QTR_LAST : qcnt_ff - 3'h1;
      if (tick) begin
        phase_ff <= phase_ff + 2'h1;
        unique case (state_ff)
          pll_ser_pkg::m_start: begin
            if (phase_ff == 2'h2) begin
              sda_rel_ff <= 1'b0;
            end else if (phase_ff == 2'h3) begin
              scl_ff <= 1'b0;
              state_ff <= pll_ser_pkg::m_bit;
              bidx_ff <= 3'h0;
              bit_ff <= 4'h0;
              sh_ff <= {pll_ser_pkg::SLAVE_ADDR, rd_mode_ff};
            end
          end
          pll_ser_pkg::m_bit: begin
            unique case (phase_ff)
              2'h0: begin
                if (bit_ff == pll_ser_pkg::BYTE_BITS) begin
                  sda_rel_ff <= !rd_data || last_byte;
                end else begin
                  sda_rel_ff <= rd_data || sh_ff[7];
                end
              end
              2'h1: scl_ff <= 1'b1;
              2'h2: begin
                if (bit_ff != pll_ser_pkg::BYTE_BITS && rd_data) begin
                  sh_ff <= {sh_ff[6:0], sda_s};
                end else if (bit_ff == pll_ser_pkg::BYTE_BITS && !rd_data && sda_s) begin
                  nack_ff <= 1'b1;
                end
              end
              2'h3: begin
                scl_ff <= 1'b0;
                if (bit_ff != pll_ser_pkg::BYTE_BITS) begin
                  bit_ff <= bit_ff + 4'h1;
                  if (!rd_data) begin
                    sh_ff <= {sh_ff[6:0], 1'b0};
                  end
                end else begin
                  if (rd_data) begin
                    rdata_ff[8*(bidx_ff - 3'h1) +: 8] <= sh_ff;
                  end
                  if (nack_ff || last_byte) begin
                    state_ff <= pll_ser_pkg::m_stop;
                  end else begin
                    bidx_ff <= bidx_ff + 3'h1;
                    bit_ff <= 4'h0;
                    sh_ff <= next_byte;
                  end
                end
              end
            endcase
          end
          pll_ser_pkg::m_stop: begin
            unique case (phase_ff)
              2'h0: sda_rel_ff <= 1'b0;
              2'h1: scl_ff <= 1'b1;
              2'h2: sda_rel_ff <= 1'b1;
              2'h3: state_ff <= pll_ser_pkg::m_idle;
            endcase
          end
          default: state_ff <= pll_ser_pkg::m_idle;
        endcase
      end
    end
  end

  assign link.serial_clock_line = scl_ff;
  assign link.m_sda_o = 1'b0;
  assign link.m_sda_oe_n = sda_rel_ff;

endmodule : two_wire_ctrl

`default_nettype wire

// File: dv/pll_link_monitor.sv
// link monitor: framing and acknowledge checks on the shared bus
`timescale 1ns/1ps
`default_nettype none
module pll_link_monitor (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset
  input wire logic serial_clock_line, // bus clock
  input wire logic m_sda_oe_n, // controller enable
  input wire logic d_sda_oe_n, // device enable
  input wire logic serial_data_line // resolved data
);
  localparam logic [7:0] WR_ADDR = {pll_ser_pkg::SLAVE_ADDR, pll_ser_pkg::DIR_WRITE};
  logic scl_q_ff, sda_q_ff, frame_ff, first_ff, wr_ff, miss_ff;
  logic [3:0] bit_ff;
  logic [7:0] sh_ff;
  logic start, stop, rise, ack9;
  assign start = scl_q_ff & serial_clock_line & sda_q_ff & ~serial_data_line;
  assign stop = scl_q_ff & serial_clock_line & ~sda_q_ff & serial_data_line;
  assign rise = ~scl_q_ff & serial_clock_line & frame_ff;
  assign ack9 = rise & (bit_ff == 4'h8);
  // ==========================================================
  // frame tracking
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
    end else begin
      scl_q_ff <= serial_clock_line;
      sda_q_ff <= serial_data_line;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_ff <= 1'b0;
      first_ff <= 1'b0;
      bit_ff <= 4'h0;
    end else if (start | stop) begin
      frame_ff <= start;
      first_ff <= 1'b1;
      bit_ff <= 4'h0;
    end else if (rise) begin
      bit_ff <= ack9 ? 4'h0 : bit_ff + 4'h1;
      first_ff <= first_ff & ~ack9;
    end
  end
  // the address stays decoded in wr_ff after the shifter moves on
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sh_ff <= 8'h00;
      wr_ff <= 1'b0;
      miss_ff <= 1'b0;
    end else if (start | stop) begin
      miss_ff <= 1'b0;
    end else if (rise && !ack9) begin
      sh_ff <= {sh_ff[6:0], serial_data_line};
    end else if (ack9 && first_ff) begin
      wr_ff <= sh_ff == WR_ADDR;
      miss_ff <= sh_ff[7:1] != pll_ser_pkg::SLAVE_ADDR;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_dev_low;
    $changed(d_sda_oe_n) |-> !serial_clock_line && !$past(serial_clock_line);
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device data moved in clock high");
  property p_ctrl_high;
    frame_ff && serial_clock_line && $past(serial_clock_line) |-> !$fell(m_sda_oe_n);
  endproperty
  a_ctrl_high: assert property (p_ctrl_high)
    else $error("controller data fell in clock high");
  property p_start_clk;
    start |-> ##[1:8] !serial_clock_line;
  endproperty
  a_start_clk: assert property (p_start_clk)
    else $error("no clock after start");
  property p_stop_idle;
    stop |-> (serial_clock_line && serial_data_line)[*4];
  endproperty
  a_stop_idle: assert property (p_stop_idle)
    else $error("bus not idle after stop");
  property p_idle;
    !frame_ff |-> serial_clock_line && d_sda_oe_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("bus active outside frame");
  property p_addr_ack;
    ack9 && first_ff |-> serial_data_line == (sh_ff[7:1] != pll_ser_pkg::SLAVE_ADDR);
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("address acknowledge wrong");
  property p_miss;
    miss_ff |-> d_sda_oe_n;
  endproperty
  a_miss: assert property (p_miss)
    else $error("device drove after address miss");
  property p_wr_ack;
    ack9 && !first_ff && wr_ff |-> !d_sda_oe_n;
  endproperty
  a_wr_ack: assert property (p_wr_ack)
    else $error("write byte not acknowledged");
endmodule : pll_link_monitor
`default_nettype wire

// File: dv/tb_top.sv
// bench: wishbone-driven controller programs the slave across the link
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================
  // stimulus and wiring
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic mpin = 1'b1;
  logic gpin = 1'b0;
  logic pll = 1'b0;
  logic [31:0] rdat;
  logic ack, byp, sel, co, cob;
  logic [7:0] c0, c1, c2;
  logic [9:0] num;
  logic [6:0] den;
  int fail_count = 0;
  int checks_done = 0;
  integer seed = 32'hdadd288d;
  always #5 clk = ~clk;
  always @(posedge clk) pll <= ~pll;
  two_wire_if two_wire_if_i ();
  two_wire_ctrl two_wire_ctrl_i (.clk(clk), .nrst(nrst), .link(two_wire_if_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack));
  pll_cfg_slave pll_cfg_slave_i (.clk(clk), .nrst(nrst), .link(two_wire_if_i),
    .mult_choice_pin(mpin), .out_gate_pin(gpin), .pll_clk_in(pll), .config_byte_zero(c0),
    .config_byte_one(c1), .reserved_byte(c2), .ref_divider_bypass(byp),
    .serial_divider_select(sel), .mult_num(num), .mult_den(den), .clk_out(co),
    .differential_out_inverted(cob));
  pll_link_monitor pll_link_monitor_i (.clk(clk), .nrst(nrst),
    .serial_clock_line(two_wire_if_i.serial_clock_line), .m_sda_oe_n(two_wire_if_i.m_sda_oe_n),
    .d_sda_oe_n(two_wire_if_i.d_sda_oe_n), .serial_data_line(two_wire_if_i.serial_data_line));
  // ==========================================================
  // tasks
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h got %h", nm, e, g);
    end
  endtask : chk
  // ack as sampled at the edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) begin
      fail_count++;
      print_verdict();
    end
  endtask : wb
  task automatic run(input logic [3:0] ctl);
    logic [31:0] s;
    int n;
    wb(1'b1, pll_ser_pkg::REG_CTRL, {28'h0, ctl}, s);
    n = 0;
    s = 32'h1;
    while (s[pll_ser_pkg::BUSY_BIT] !== 1'b0 && n < 1000) begin
      wb(1'b0, pll_ser_pkg::REG_STATUS, 32'h0, s);
      n++;
    end
    if (n >= 1000) begin
      fail_count++;
      print_verdict();
    end
    chk("nack", 1'b0, s[pll_ser_pkg::NACK_BIT]);
  endtask : run
  function automatic logic [9:0] e_num(input logic [7:0] b0, input logic [7:0] b1, input logic p);
    return b0[6] ? ({2'b00, b1} + 10'h003) * 10'h002 : (p ? 10'h008 : 10'h010);
  endfunction : e_num
  function automatic logic [6:0] e_den(input logic [7:0] b0);
    return (!b0[6] || b0[7]) ? 7'h01 : {1'b0, b0[5:0]} + 7'h02;
  endfunction : e_den
  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] x;
    logic [31:0] r;
    logic [23:0] e;
    e = 24'h0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk("select", 1'b0, sel);
    chk("bypass", 1'b0, byp);
    chk("num", 10'h008, num);
    for (int k = 0; k < 8; k++) begin
      x = $random(seed);
      if (k == 0) x[7:0] = 8'hc0;
      if (k == 1) x[15:0] = 16'hff7f;
      mpin <= x[24];
      wb(1'b1, pll_ser_pkg::REG_WDATA, x, r);
      run({~k[1:0], 2'b01});
      if (k[1:0] != 2'd3) e[7:0] = x[7:0];
      if (k[1:0] < 2'd2) e[15:8] = x[15:8];
      if (k[1:0] == 2'd0) e[23:16] = x[23:16];
      repeat (4) @(posedge clk);
      chk("byte0", e[7:0], c0);
      chk("byte1", e[15:8], c1);
      chk("rsvd", e[23:16], c2);
      chk("bypass", e[7], byp);
      chk("select", e[6], sel);
      chk("num", e_num(e[7:0], e[15:8], mpin), num);
      chk("den", e_den(e[7:0]), den);
      run(4'hf);
      wb(1'b0, pll_ser_pkg::REG_RDATA, 32'h0, r);
      chk("readback", e, r[23:0]);
    end
    repeat (6) @(posedge clk);
    chk("gated", 2'b00, {co, cob});
    gpin <= 1'b1;
    repeat (6) @(posedge clk);
    chk("open", 1'b1, co ^ cob);
    wb(1'b0, 4'h2, 32'h0, r);
    chk("unmapped", 32'h0, r);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
